//--- pwm_fan_pkg.sv
// shared types and constants for the pwm pi and fan stage controller
package pwm_fan_pkg;
  localparam int TW = 16;
  localparam int CVW = 8;
  localparam logic [CVW-1:0] CV_FULL = 8'h64;
  localparam logic [31:0] CLK_HZ = 32'h05F5E100;
  localparam logic [31:0] TICK_US = 32'h000F4240;
  localparam logic [31:0] TICK_CYC = TICK_US * (CLK_HZ / 32'h000F4240);
  localparam logic [TW-1:0] STAGE_ONE_DEF = 16'h0000;
  localparam logic [TW-1:0] STAGE_TWO_DEF = 16'h0032;
  localparam logic [TW-1:0] STAGE_THREE_DEF = 16'h0064;
  localparam logic [TW-1:0] FAN_HYST_DEF = 16'h001E;
  localparam logic [TW-1:0] VALVE_HYST_DEF = 16'h001E;
  localparam logic [TW-1:0] BAND_DEF = 16'h01F4;
  localparam logic [15:0] TI_DEF = 16'h0096;
  localparam logic [15:0] PERIOD_DEF = 16'h0384;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_SETPT = 12'h004;
  localparam logic [11:0] A_ROOM = 12'h008;
  localparam logic [11:0] A_OFS1 = 12'h00C;
  localparam logic [11:0] A_OFS2 = 12'h010;
  localparam logic [11:0] A_OFS3 = 12'h014;
  localparam logic [11:0] A_FHYS = 12'h018;
  localparam logic [11:0] A_VHYS = 12'h01C;
  localparam logic [11:0] A_BAND = 12'h020;
  localparam logic [11:0] A_TI = 12'h024;
  localparam logic [11:0] A_PER = 12'h028;
  localparam logic [11:0] A_STAT = 12'h02C;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [TW-1:0] Z16 = 16'h0000;
  localparam logic [47:0] SEC_PER_MIN = 48'h00000000003C;
  typedef struct packed {
    logic cooling;
    logic [1:0] speeds;
  } ctrl_t;
  typedef struct packed {
    logic pwm_out;
    logic valve_open;
    logic [2:0] fan;
  } act_t;
endpackage : pwm_fan_pkg

//--- pwm_fan_ctrl.sv
// pwm pi output and staged fan coil controller with axi4-lite registers
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module pwm_fan_ctrl
  import pwm_fan_pkg::*;
#(
  parameter logic [31:0] TICK_CYCLES = TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pwm_fan_pkg::act_t act
);
  import pwm_fan_pkg::*;

  // temperatures are signed centi-degrees Celsius; the tick is one second
  typedef struct packed {
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ctrl_t ctrl;
    logic [TW-1:0] setpt;
    logic [TW-1:0] room;
    logic [TW-1:0] ofs1;
    logic [TW-1:0] ofs2;
    logic [TW-1:0] ofs3;
    logic [TW-1:0] fhys;
    logic [TW-1:0] vhys;
    logic [TW-1:0] band;
    logic [15:0] ti;
    logic [15:0] period;
    logic [31:0] tick_cnt;
    logic [15:0] sec;
    logic [15:0] on_time;
    logic [31:0] integ;
    logic [CVW-1:0] cv;
    logic restart;
    logic [2:0] want;
    act_t act;
  } state_t;

  state_t s_r, s_nxt;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  logic signed [17:0] err;
  logic signed [17:0] th_on [3];
  logic signed [17:0] th_off [3];
  logic [2:0] stage;
  logic signed [47:0] pterm;
  logic signed [47:0] iterm;
  logic signed [47:0] cv_full;
  logic tick;
  logic wr_fire;
  logic [15:0] ofs [3];

  // heating and cooling share one comparison on the mode-signed error
  always_comb begin
    ofs[0] = s_r.ofs1;
    ofs[1] = s_r.ofs2;
    ofs[2] = s_r.ofs3;
    if (s_r.ctrl.cooling) begin
      err = $signed({{2{s_r.room[TW-1]}}, s_r.room}) - $signed({{2{s_r.setpt[TW-1]}}, s_r.setpt});
    end else begin
      err = $signed({{2{s_r.setpt[TW-1]}}, s_r.setpt}) - $signed({{2{s_r.room[TW-1]}}, s_r.room});
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      assign th_off[g] = $signed({2'b00, ofs[g]});
      assign th_on[g] = $signed({2'b00, ofs[g]}) + $signed({2'b00, s_r.fhys});
      // one driver per bit; inside the band the stage keeps its last request
      assign stage[g] = (2'(g) >= s_r.ctrl.speeds) ? 1'b0 :
                        (err > th_on[g]) ? 1'b1 :
                        (err <= th_off[g]) ? 1'b0 : s_r.want[g];
    end
  endgenerate

  always_comb begin
    // all operands signed, else a negative error turns into a huge positive one
    pterm = 48'(err) * $signed(48'(CV_FULL)) / $signed(48'(s_r.band | 16'h0001));
    // integ sums error times full scale each second; scale by band, ti and seconds
    iterm = 48'($signed(s_r.integ)) / ($signed(48'(s_r.band | 16'h0001)) *
            $signed(48'(s_r.ti | 16'h0001)) * $signed(SEC_PER_MIN));
    cv_full = pterm + iterm;
  end

  assign tick = (s_r.tick_cnt >= TICK_CYCLES - 32'h1);
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;

  always_comb begin
    logic [15:0] v;
    logic [2:0] speed;
    logic valve_nxt;
    logic signed [47:0] integ_n;
    logic [CVW-1:0] cv_c;
    logic sp_wr;
    v = 16'h0000;
    speed = 3'b000;
    valve_nxt = s_r.act.valve_open;
    integ_n = 48'($signed(s_r.integ));
    cv_c = s_r.cv;
    sp_wr = 1'b0;
    s_nxt = s_r;
    s_nxt.tick_cnt = tick ? 32'h0 : s_r.tick_cnt + 32'h1;
    // axi write: address and data accepted independently
    if (s_axi_awvalid && !s_r.aw_got) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OK;
      unique case ({s_r.awaddr[11:2], 2'b00})
        A_CTRL: begin
          if (s_r.wstrb[0]) begin
            s_nxt.ctrl = ctrl_t'(s_r.wdata[2:0]);
          end
        end
        A_SETPT: begin
          s_nxt.setpt = merge16(s_r.setpt, s_r.wdata, s_r.wstrb);
          s_nxt.restart = 1'b1;
          sp_wr = 1'b1;
        end
        A_ROOM: s_nxt.room = merge16(s_r.room, s_r.wdata, s_r.wstrb);
        A_OFS1: s_nxt.ofs1 = merge16(s_r.ofs1, s_r.wdata, s_r.wstrb);
        A_OFS2: s_nxt.ofs2 = merge16(s_r.ofs2, s_r.wdata, s_r.wstrb);
        A_OFS3: s_nxt.ofs3 = merge16(s_r.ofs3, s_r.wdata, s_r.wstrb);
        A_FHYS: s_nxt.fhys = merge16(s_r.fhys, s_r.wdata, s_r.wstrb);
        A_VHYS: s_nxt.vhys = merge16(s_r.vhys, s_r.wdata, s_r.wstrb);
        A_BAND: s_nxt.band = merge16(s_r.band, s_r.wdata, s_r.wstrb);
        A_TI: s_nxt.ti = merge16(s_r.ti, s_r.wdata, s_r.wstrb);
        A_PER: s_nxt.period = merge16(s_r.period, s_r.wdata, s_r.wstrb);
        A_STAT: ;
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OK;
      unique case ({s_axi_araddr[11:2], 2'b00})
        A_CTRL: v = {13'h0, s_r.ctrl};
        A_SETPT: v = s_r.setpt;
        A_ROOM: v = s_r.room;
        A_OFS1: v = s_r.ofs1;
        A_OFS2: v = s_r.ofs2;
        A_OFS3: v = s_r.ofs3;
        A_FHYS: v = s_r.fhys;
        A_VHYS: v = s_r.vhys;
        A_BAND: v = s_r.band;
        A_TI: v = s_r.ti;
        A_PER: v = s_r.period;
        A_STAT: v = {3'h0, s_r.cv, s_r.act};
        default: begin
          v = 16'h0000;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
      s_nxt.rdata = {16'h0000, v};
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // pi and pwm advance once per second; a restart is handled on the next second
    if (tick) begin
      if (s_r.restart || s_r.sec + 16'h1 >= s_r.period) begin
        if (cv_full <= 48'sh0) begin
          cv_c = 8'h00;
        end else if (cv_full >= $signed(48'(CV_FULL))) begin
          cv_c = CV_FULL;
        end else begin
          cv_c = cv_full[CVW-1:0];
        end
        s_nxt.cv = cv_c;
        s_nxt.sec = 16'h0;
        // a setpoint written in this very cycle must still restart the next one
        s_nxt.restart = sp_wr;
        s_nxt.on_time = 16'((32'(s_r.period) * 32'(cv_c)) / 32'(CV_FULL));
      end else begin
        s_nxt.sec = s_r.sec + 16'h1;
      end
      // no division here, so small errors still accumulate; large band and ti may overflow
      integ_n = integ_n + 48'(err) * $signed(48'(CV_FULL));
      // wind-up stops only while the error still pushes upwards
      if (iterm > $signed(48'(CV_FULL)) && !err[17]) begin
        integ_n = 48'($signed(s_r.integ));
      end
      if (integ_n < 48'sh0 && !err[17]) begin
        integ_n = 48'sh0;
      end
      s_nxt.integ = integ_n[31:0];
      s_nxt.act.pwm_out = (s_nxt.sec < s_nxt.on_time);
      // valve two point hysteresis
      if (err > $signed({2'b00, s_r.vhys})) begin
        valve_nxt = 1'b1;
      end else if (err <= 18'sh0) begin
        valve_nxt = 1'b0;
      end
      s_nxt.act.valve_open = valve_nxt;
      // highest requested stage wins, lower stages forced off
      if (stage[2]) begin
        speed = 3'b100;
      end else if (stage[1]) begin
        speed = 3'b010;
      end else if (stage[0]) begin
        speed = 3'b001;
      end
      if (s_r.act.valve_open && !valve_nxt) begin
        speed[0] = 1'b0;
      end
      s_nxt.want = stage;
      // a speed change passes through all-off for one tick to protect the motor
      if (speed != s_r.act.fan && s_r.act.fan != 3'b000 && speed != 3'b000) begin
        s_nxt.act.fan = 3'b000;
      end else begin
        s_nxt.act.fan = speed;
      end
    end
    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.ctrl.speeds = 2'h3;
      s_nxt.ofs1 = STAGE_ONE_DEF;
      s_nxt.ofs2 = STAGE_TWO_DEF;
      s_nxt.ofs3 = STAGE_THREE_DEF;
      s_nxt.fhys = FAN_HYST_DEF;
      s_nxt.vhys = VALVE_HYST_DEF;
      s_nxt.band = BAND_DEF;
      s_nxt.ti = TI_DEF;
      s_nxt.period = PERIOD_DEF;
      s_nxt.restart = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign s_axi_awready = !s_r.aw_got;
  assign s_axi_wready = !s_r.w_got;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign act = s_r.act;
endmodule : pwm_fan_ctrl

//--- fan_ctrl_checker.sv
// concurrent checks on the fan coil controller ports
`timescale 1ns/100ps
module fan_ctrl_checker
  import pwm_fan_pkg::*;
#(
  parameter logic [31:0] TICK_CYCLES = TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pwm_fan_pkg::act_t act
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  one_speed_a: assert property ($onehot0(act.fan)) else $error("two fan speeds driven");
  speed_gap_a: assert property ((act.fan != 3'h0 && $changed(act.fan)) |-> $past(act.fan) == 3'h0)
    else $error("speed changed without off step");
  first_off_a: assert property ($rose(act.fan[1]) |-> $past(act.fan[0]) == 1'b0)
    else $error("speed one still on before speed two");
  second_off_a: assert property ($rose(act.fan[2]) |-> $past(act.fan) == 3'h0)
    else $error("speed two still on before speed three");
  valve_fan_a: assert property ($fell(act.valve_open) |-> !act.fan[0])
    else $error("speed one kept after valve close");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  reset_quiet_a: assert property (!$past(aresetn) |-> act == 5'h00 && !s_axi_bvalid)
    else $error("outputs active after reset");
  cover property (act.fan == 3'h4);
  cover property ($rose(act.valve_open));
  cover property (act.pwm_out ##1 !act.pwm_out);
endmodule : fan_ctrl_checker

//--- coil_actuators.sv
// on/off valve and fan coil speed actuator model
`timescale 1ns/100ps
module coil_actuators
  import pwm_fan_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pwm_fan_pkg::act_t act,
  output logic motor_fault,
  output logic dry_coil
);
  // faults latch so that a one-tick overlap is never missed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_fault <= 1'b0;
      dry_coil <= 1'b0;
    end else begin
      if (!$onehot0(act.fan)) motor_fault <= 1'b1;
      if (act.fan[0] && !act.valve_open) dry_coil <= 1'b1;
    end
  end
endmodule : coil_actuators

//--- tb.sv
// testbench for the pwm pi and fan stage controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  import pwm_fan_pkg::*;
  localparam logic [31:0] TK = 32'h0000000A;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic motor_fault, dry_coil;
  act_t act;
  int bad_count = 0, total_checks = 0, hi;
  always #5 aclk = ~aclk;
  pwm_fan_ctrl #(.TICK_CYCLES(TK)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .act);
  coil_actuators far (.aclk, .aresetn, .act, .motor_fault, .dry_coil);
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // handshakes are judged at the falling edge, released after the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) ta = 1'b1;
      if (s_axi_wvalid && s_axi_wready) tw = 1'b1;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    // bready comes late so that a response held against a low bready is seen
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic tk(input int n);
    repeat (n * 10) @(posedge aclk);
    @(negedge aclk);
  endtask : tk
  // outputs move only on ticks, so four ticks cover the all-off step too
  task automatic room(input logic [15:0] t, input logic v, input logic [2:0] f);
    wr(A_ROOM, {16'h0000, t});
    tk(4);
    `CHK("valve", v, act.valve_open)
    `CHK("fan", f, act.fan)
  endtask : room
  task automatic duty(input int e);
    hi = 0;
    repeat (200) begin
      @(negedge aclk);
      hi += act.pwm_out;
    end
    `CHK("pwm duty", 1'b1, e ? hi == 200 : hi > 0 && hi < 200)
  endtask : duty
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(A_OFS1); `CHK("ofs1", 32'h00000000, rd)
    rdr(A_OFS3); `CHK("ofs3", {Z16, STAGE_THREE_DEF}, rd)
    rdr(12'h030); `CHK("rresp", RESP_SLVERR, resp)
    wr(12'h030, 32'h00000001); `CHK("bresp", RESP_SLVERR, resp)
    wr(A_FHYS, 32'h0000001E); `CHK("fhys", RESP_OK, resp)
    rdr(A_PER); `CHK("period", {Z16, PERIOD_DEF}, rd)
    wr(A_PER, 32'h00000258);
    rdr(A_PER); `CHK("air period", 32'h00000258, rd)
    wr(A_SETPT, 32'h000007D0);
    room(16'h07B2, 1'b0, 3'h0);
    room(16'h07B1, 1'b1, 3'h1);
    room(16'h074D, 1'b1, 3'h4);
    wr(A_PER, 32'h00000014);
    wr(A_SETPT, 32'h000007D0);
    tk(2); `CHK("pwm restart", 1'b1, act.pwm_out)
    duty(0);
    room(16'h0000, 1'b1, 3'h4);
    wr(A_SETPT, 32'h000007D0);
    tk(2);
    duty(1);
    rdr(A_STAT); `CHK("status", {19'h00000, CV_FULL, 1'b1, 1'b1, 3'h4}, rd)
    room(16'h07D0, 1'b0, 3'h0);
    wr(A_CTRL, 32'h00000007);
    room(16'h080D, 1'b1, 3'h1);
    room(16'h0821, 1'b1, 3'h2);
    wr(A_CTRL, 32'h00000005);
    room(16'h0898, 1'b1, 3'h1);
    `CHK("motor", 1'b0, motor_fault)
    `CHK("coil", 1'b0, dry_coil)
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    finish_test;
  end
endmodule : tb
bind pwm_fan_ctrl fan_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .act(act));
